/* ctm_pkg.sv */
package ctm_pkg;
   // Register byte addresses on the bus
   localparam logic [4:0] OFF_PFS = 5'h00;
   localparam logic [4:0] OFF_C0 = 5'h04;
   localparam logic [4:0] OFF_C1 = 5'h08;
   localparam logic [4:0] OFF_CNT_LO = 5'h0c;
   localparam logic [4:0] OFF_CNT_HI = 5'h10;
   localparam logic [4:0] OFF_MA_LO = 5'h14;
   localparam logic [4:0] OFF_MA_HI = 5'h18;
   // Reset values and pin select write mask
   localparam logic [7:0] PFS_RST = 8'h05;
   localparam logic [7:0] PFS_MASK = 8'h1f;
   localparam logic [7:0] C0_RST = 8'h00;
   localparam logic [7:0] C1_RST = 8'h00;
   // Control zero fields
   localparam int C0_PAUSE_BIT = 7;
   localparam int C0_CK_LSB = 4;
   localparam int C0_ON_BIT = 3;
   localparam int C0_RP_LSB = 0;
   // Control one fields
   localparam int C1_MODE_LSB = 6;
   localparam int C1_IO_LSB = 4;
   localparam int C1_OC_BIT = 3;
   localparam int C1_POL_BIT = 2;
   localparam int C1_CCLR_BIT = 0;
   // Prescaler ratios
   localparam int DIV_SYS = 4;
   localparam int DIV_H_LO = 16;
   localparam int DIV_H_HI = 64;

   typedef enum logic [2:0] {
      CK_SYS4 = 3'h0,
      CK_SYS = 3'h1,
      CK_H16 = 3'h2,
      CK_H64 = 3'h3,
      CK_TBC = 3'h4,
      CK_TBC_ALT = 3'h5,
      CK_EXT_RISE = 3'h6,
      CK_EXT_FALL = 3'h7
   } ctm_clk_t;

   typedef enum logic [1:0] {
      MD_CMP = 2'h0,
      MD_UNDEF = 2'h1,
      MD_PWM = 2'h2,
      MD_TMR = 2'h3
   } ctm_mode_t;

   typedef enum logic [1:0] {
      ACT_NONE = 2'h0,
      ACT_LOW = 2'h1,
      ACT_HIGH = 2'h2,
      ACT_TOGGLE = 2'h3
   } ctm_act_t;
endpackage

/* ctm_if.sv */
interface ctm_tick_if;
   logic [2:0] ck_sel;
   logic tick;
   modport src (input ck_sel, output tick);
   modport core (output ck_sel, input tick);
endinterface

interface ctm_out_if;
   logic [1:0] mode;
   logic [1:0] action;
   logic init_lvl;
   logic pol;
   logic on_rise;
   logic match_a;
   modport drv (input mode, input action, input init_lvl, input pol, input on_rise,
                input match_a);
   modport core (output mode, output action, output init_lvl, output pol, output on_rise,
                 output match_a);
endinterface

/* ctm_clk_sel.sv */
module ctm_clk_sel (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Internal clock enables and external pin
   input wire logic hclk_en_i,
   input wire logic tbc_en_i,
   input wire logic ext_count_input_i,
   // Selected tick
   ctm_tick_if.src tk
);
   import ctm_pkg::*;

   logic [1:0] sdiv_r, sdiv_nxt;
   logic [5:0] hdiv_r, hdiv_nxt;
   logic [2:0] sync_r, sync_nxt;
   logic ext_rise, ext_fall;

   always_comb begin
      sdiv_nxt = sdiv_r + 2'h1;
      hdiv_nxt = hclk_en_i ? hdiv_r + 6'h01 : hdiv_r;
      sync_nxt = {sync_r[1:0], ext_count_input_i};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sdiv_r <= 2'h0;
         hdiv_r <= 6'h00;
         sync_r <= 3'h0;
      end else begin
         sdiv_r <= sdiv_nxt;
         hdiv_r <= hdiv_nxt;
         sync_r <= sync_nxt;
      end
   end

   // Edge seen between second and third stage only
   assign ext_rise = sync_r[1] & ~sync_r[2];
   assign ext_fall = ~sync_r[1] & sync_r[2];

   always_comb begin
      case (ctm_clk_t'(tk.ck_sel))
         CK_SYS4: tk.tick = (sdiv_r == 2'(DIV_SYS - 1));
         CK_SYS: tk.tick = 1'b1;
         CK_H16: tk.tick = hclk_en_i && (hdiv_r[3:0] == 4'(DIV_H_LO - 1));
         CK_H64: tk.tick = hclk_en_i && (hdiv_r == 6'(DIV_H_HI - 1));
         CK_TBC, CK_TBC_ALT: tk.tick = tbc_en_i;
         CK_EXT_RISE: tk.tick = ext_rise;
         default: tk.tick = ext_fall;
      endcase
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ext_rise_tick: assert property ((tk.ck_sel == 3'h6 && sync_r[1] && !sync_r[2])
      |-> tk.tick) else $error("rising pin edge gave no tick");
   a_ext_fall_tick: assert property ((tk.ck_sel == 3'h7 && tk.tick) |-> (!sync_r[1]
      && sync_r[2])) else $error("falling tick without falling edge");
   a_sys4_spacing: assert property ((tk.ck_sel == 3'h0 && $stable(tk.ck_sel) && tk.tick)
      |=> !tk.tick [*3]) else $error("system divide by four ticked too soon");
endmodule // ctm_clk_sel

/* ctm_out_ctl.sv */
module ctm_out_ctl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control from timer core
   ctm_out_if.drv oc,
   // Pin steering
   input wire logic first_en_i,
   input wire logic second_en_i,
   input wire logic [1:0] port_inv_i,
   input wire logic alt_first_i,
   input wire logic alt_second_i,
   // Pins
   output logic first_o,
   output logic second_o
);
   import ctm_pkg::*;

   logic lvl_r, lvl_nxt;
   logic first_r, first_nxt, second_r, second_nxt;
   logic drv;

   always_comb begin
      lvl_nxt = lvl_r;
      if (ctm_mode_t'(oc.mode) == MD_CMP) begin
         if (oc.on_rise) begin
            lvl_nxt = oc.init_lvl;
         end else if (oc.match_a) begin
            case (ctm_act_t'(oc.action))
               ACT_LOW: lvl_nxt = 1'b0;
               ACT_HIGH: lvl_nxt = 1'b1;
               ACT_TOGGLE: lvl_nxt = ~lvl_r;
               default: lvl_nxt = lvl_r;
            endcase
         end
      end
      drv = (ctm_mode_t'(oc.mode) == MD_TMR) ? lvl_nxt : lvl_nxt ^ oc.pol;
      first_nxt = first_en_i ? drv ^ port_inv_i[0] : alt_first_i;
      second_nxt = second_en_i ? drv ^ port_inv_i[1] : alt_second_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_r <= 1'b0;
         first_r <= 1'b0;
         second_r <= 1'b0;
      end else begin
         lvl_r <= lvl_nxt;
         first_r <= first_nxt;
         second_r <= second_nxt;
      end
   end

   assign first_o = first_r;
   assign second_o = second_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_init_level: assert property ((oc.on_rise && oc.mode == 2'h0) |=>
      lvl_r == $past(oc.init_lvl)) else $error("output not returned to initial level");
   a_match_toggle: assert property ((oc.match_a && !oc.on_rise && oc.mode == 2'h0
      && oc.action == 2'h3) |=> lvl_r != $past(lvl_r)) else $error("toggle missed");
   a_pin_release: assert property (!second_en_i |=> second_o == $past(alt_second_i))
      else $error("disabled pin lost its shared function");
endmodule // ctm_out_ctl

/* ctm_timer.sv */
module ctm_timer #(
   parameter int CNT_W = 10,
   parameter int TM_IDX = 0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Clock sources
   input wire logic hclk_en_i,
   input wire logic tbc_en_i,
   input wire logic ext_count_input_i,
   // Output pins and their shared functions
   input wire logic [1:0] port_inv_i,
   input wire logic alt_first_i,
   input wire logic alt_second_i,
   output logic timer_first_output_o,
   output logic timer_second_output_o,
   output logic [4:0] pin_func_sel_o,
   // Comparator events
   output logic match_a_evt_o,
   output logic period_evt_o
);
   import ctm_pkg::*;

   logic [7:0] pfs_r, pfs_nxt, c0_r, c0_nxt, c1_r, c1_nxt, stage_r, stage_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt, match_a_value_r, match_a_value_nxt;
   logic [31:0] rdat_r, rdat_nxt;
   logic ack_r, ack_nxt, a_evt_r, a_evt_nxt, p_evt_r, p_evt_nxt;
   logic req, wr, rd, on_rise, run_tick, a_hit, p_hit, clr_sel;
   logic [CNT_W:0] inc;
   logic [2:0] per;

   ctm_tick_if tk ();
   ctm_out_if oc ();

   ctm_clk_sel u_clk_sel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hclk_en_i(hclk_en_i),
      .tbc_en_i(tbc_en_i),
      .ext_count_input_i(ext_count_input_i),
      .tk(tk.src)
   );

   ctm_out_ctl u_out_ctl (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .oc(oc.drv),
      .first_en_i(pfs_r[2 * TM_IDX]),
      .second_en_i(pfs_r[2 * TM_IDX + 1]),
      .port_inv_i(port_inv_i),
      .alt_first_i(alt_first_i),
      .alt_second_i(alt_second_i),
      .first_o(timer_first_output_o),
      .second_o(timer_second_output_o)
   );

   // Bus request is taken once; ack follows on the next edge
   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign rd = req & ~wb_we_i;
   assign on_rise = wr && (wb_adr_i == OFF_C0) && wb_dat_i[C0_ON_BIT] && !c0_r[C0_ON_BIT];

   assign tk.ck_sel = c0_r[C0_CK_LSB +: 3];
   assign per = c0_r[C0_RP_LSB +: 3];
   assign clr_sel = c1_r[C1_CCLR_BIT];

   assign oc.mode = c1_r[C1_MODE_LSB +: 2];
   assign oc.action = c1_r[C1_IO_LSB +: 2];
   assign oc.init_lvl = c1_r[C1_OC_BIT];
   assign oc.pol = c1_r[C1_POL_BIT];
   assign oc.on_rise = on_rise;
   assign oc.match_a = a_hit;

   // Counter and comparators
   always_comb begin
      run_tick = c0_r[C0_ON_BIT] & ~c0_r[C0_PAUSE_BIT] & tk.tick;
      inc = {1'b0, cnt_r} + {{CNT_W{1'b0}}, 1'b1};
      a_hit = run_tick && (inc[CNT_W-1:0] == match_a_value_r) && (match_a_value_r != '0);
      if (per == 3'h0) begin
         p_hit = run_tick && inc[CNT_W];
      end else begin
         p_hit = run_tick && (inc[CNT_W-1 -: 3] == per) && (inc[CNT_W-4:0] == '0);
      end
      cnt_nxt = cnt_r;
      if (on_rise) begin
         cnt_nxt = '0;
      end else if (run_tick) begin
         if (clr_sel ? a_hit : p_hit) begin
            cnt_nxt = '0;
         end else begin
            cnt_nxt = inc[CNT_W-1:0];
         end
      end
      a_evt_nxt = a_hit && !on_rise;
      p_evt_nxt = p_hit && !clr_sel && !on_rise;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         a_evt_r <= 1'b0;
         p_evt_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         a_evt_r <= a_evt_nxt;
         p_evt_r <= p_evt_nxt;
      end
   end

   // Register file with shared low-byte staging buffer
   always_comb begin
      pfs_nxt = pfs_r;
      c0_nxt = c0_r;
      c1_nxt = c1_r;
      stage_nxt = stage_r;
      match_a_value_nxt = match_a_value_r;
      rdat_nxt = rdat_r;
      ack_nxt = req;
      if (wr) begin
         if (wb_adr_i == OFF_PFS) begin
            pfs_nxt = wb_dat_i[7:0] & PFS_MASK;
         end else if (wb_adr_i == OFF_C0) begin
            c0_nxt = wb_dat_i[7:0];
         end else if (wb_adr_i == OFF_C1) begin
            c1_nxt = wb_dat_i[7:0];
         end else if (wb_adr_i == OFF_MA_LO) begin
            stage_nxt = wb_dat_i[7:0];
         end else if (wb_adr_i == OFF_MA_HI) begin
            match_a_value_nxt = {wb_dat_i[CNT_W-9:0], stage_r};
         end
      end
      if (rd) begin
         if (wb_adr_i == OFF_PFS) begin
            rdat_nxt = {24'h000000, pfs_r};
         end else if (wb_adr_i == OFF_C0) begin
            rdat_nxt = {24'h000000, c0_r};
         end else if (wb_adr_i == OFF_C1) begin
            rdat_nxt = {24'h000000, c1_r};
         end else if (wb_adr_i == OFF_CNT_LO || wb_adr_i == OFF_MA_LO) begin
            rdat_nxt = {24'h000000, stage_r};
         end else if (wb_adr_i == OFF_CNT_HI) begin
            rdat_nxt = 32'(cnt_r[CNT_W-1:8]);
            stage_nxt = cnt_r[7:0];
         end else if (wb_adr_i == OFF_MA_HI) begin
            rdat_nxt = 32'(match_a_value_r[CNT_W-1:8]);
            stage_nxt = match_a_value_r[7:0];
         end else begin
            rdat_nxt = 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pfs_r <= PFS_RST;
         c0_r <= C0_RST;
         c1_r <= C1_RST;
         stage_r <= 8'h00;
         match_a_value_r <= '0;
         rdat_r <= 32'h00000000;
         ack_r <= 1'b0;
      end else begin
         pfs_r <= pfs_nxt;
         c0_r <= c0_nxt;
         c1_r <= c1_nxt;
         stage_r <= stage_nxt;
         match_a_value_r <= match_a_value_nxt;
         rdat_r <= rdat_nxt;
         ack_r <= ack_nxt;
      end
   end

   assign wb_dat_o = rdat_r;
   assign wb_ack_o = ack_r;
   assign pin_func_sel_o = pfs_r[4:0];
   assign match_a_evt_o = a_evt_r;
   assign period_evt_o = p_evt_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_on_clears: assert property ($rose(c0_r[C0_ON_BIT]) |-> cnt_r == '0)
      else $error("switching on did not clear the counter");
   a_off_holds: assert property ((!c0_r[C0_ON_BIT] && $past(!c0_r[C0_ON_BIT])) |->
      $stable(cnt_r)) else $error("counter moved while off");
   a_pause_holds: assert property ((c0_r[C0_PAUSE_BIT] && $past(c0_r[C0_PAUSE_BIT])
      && !$rose(c0_r[C0_ON_BIT])) |-> $stable(cnt_r))
      else $error("counter moved while paused");
   a_count_step: assert property ((run_tick && !on_rise) |=> (cnt_r == '0 ||
      cnt_r == $past(cnt_r) + 1'b1)) else $error("counter step wrong");
   a_match_a_evt: assert property (a_evt_r |-> cnt_r == (($past(clr_sel) || $past(p_hit)) ?
      '0 : $past(match_a_value_r))) else $error("match A event without match");
   a_period_clear: assert property (p_evt_r |-> (cnt_r == '0 && !$past(clr_sel)))
      else $error("period event did not clear counter");
   a_pfs_reserved: assert property (pfs_r[7:5] == 3'h0)
      else $error("reserved pin select bits set");
   a_stage_on_read: assert property ((rd && wb_adr_i == OFF_CNT_HI) |=>
      stage_r == $past(cnt_r[7:0])) else $error("high read did not stage low byte");
   a_stage_commit: assert property ((wr && wb_adr_i == OFF_MA_HI) |=>
      match_a_value_r == {$past(wb_dat_i[1:0]), $past(stage_r)}) else $error("match commit wrong");
   a_count_ro: assert property ((wr && (wb_adr_i == OFF_CNT_LO || wb_adr_i == OFF_CNT_HI)
      && !run_tick && !on_rise) |=> $stable(cnt_r))
      else $error("count register took a write");
endmodule // ctm_timer

/* ctm_ext_src.sv */
module ctm_ext_src (
   // Clock and request
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [7:0] n_i,
   // Far side signals
   output logic ext_o,
   output logic busy_o,
   output logic hclk_en_o,
   output logic tbc_en_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] left;
   logic [2:0] ph;
   initial begin
      ext_o = 1'b0;
      busy_o = 1'b0;
      hclk_en_o = 1'b0;
      tbc_en_o = 1'b0;
      left = 8'h0;
      ph = 3'h0;
   end
   // Internal clock enables run every other cycle
   always @(posedge clk_i) begin
      hclk_en_o <= ~hclk_en_o;
      tbc_en_o <= ~tbc_en_o;
   end
   // Burst of n pulses, 3 cycles high, 5 low; pin rests low between bursts
   always @(posedge clk_i) begin
      if (go_i) begin
         left <= n_i;
         busy_o <= (n_i != 8'h0);
         ph <= 3'h0;
      end else if (busy_o) begin
         ph <= ph + 3'h1;
         if (ph == 3'h2) ext_o <= 1'b1;
         if (ph == 3'h5) begin
            ext_o <= 1'b0;
            left <= left - 8'h1;
            if (left == 8'h1) busy_o <= 1'b0;
         end
      end
   end
endmodule // ctm_ext_src

/* tb_ctm_timer.sv */
module tb_ctm_timer;
   timeunit 1ns;
   timeprecision 1ns;
   import ctm_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [4:0] wb_adr = 5'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0, wb_dat_o;
   logic wb_ack_o, hclk_en, tbc_en, ext_pin, go = 1'b0, busy, first_o, second_o;
   logic ma_evt, pe_evt, alt_a = 1'b0, alt_b = 1'b0;
   logic [1:0] pinv = 2'h0;
   logic [7:0] npul = 8'h0;
   logic [4:0] pfs_o;
   logic [7:0] rd_q[$];
   int num_errors = 0, n_checks = 0, n_ma = 0, n_pe = 0, cycles = 0;
   logic [31:0] seed = 32'h7bd2;

   always #50 clk = ~clk;

   ctm_ext_src ctm_ext_src_i (.clk_i(clk), .go_i(go), .n_i(npul), .ext_o(ext_pin),
      .busy_o(busy), .hclk_en_o(hclk_en), .tbc_en_o(tbc_en));

   ctm_timer ctm_timer_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hclk_en_i(hclk_en), .tbc_en_i(tbc_en),
      .ext_count_input_i(ext_pin), .port_inv_i(pinv), .alt_first_i(alt_a),
      .alt_second_i(alt_b), .timer_first_output_o(first_o),
      .timer_second_output_o(second_o), .pin_func_sel_o(pfs_o), .match_a_evt_o(ma_evt),
      .period_evt_o(pe_evt));

   task automatic final_report();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_sel <= 4'h1;
      wb_dat <= {24'h0, d};
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wb_rd(input logic [4:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 8'h0);
   endtask

   task automatic rdcnt(input logic [9:0] e);
      wb_rd(OFF_CNT_HI, {6'h0, e[9:8]});
      wb_rd(OFF_CNT_LO, e[7:0]);
   endtask

   task automatic pulse(input logic [7:0] n);
      @(posedge clk);
      go <= 1'b1;
      npul <= n;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
      repeat (6) @(posedge clk);
   endtask

   task automatic gap(input int e);
      int n;
      while (pe_evt !== 1'b1) @(posedge clk);
      @(posedge clk);
      n = 1;
      while (pe_evt !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      chk("period_gap", e, n);
   endtask

   // Read results are compared in order of request
   always @(posedge clk) begin
      if (wb_ack_o === 1'b1 && wb_we === 1'b0) begin
         chk("read_data", {24'h0, rd_q.pop_front()}, wb_dat_o);
      end
      if (ma_evt === 1'b1) n_ma++;
      if (pe_evt === 1'b1) n_pe++;
      cycles++;
      if (cycles == 80000) begin
         num_errors++;
         final_report();
      end
   end

   initial begin
      logic [2:0] ck_t[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1};
      logic [2:0] rp_t[6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0};
      int gp_t[6] = '{512, 128, 4096, 16384, 256, 1024};
      ctm_act_t act_t[3] = '{ACT_TOGGLE, ACT_HIGH, ACT_LOW};
      logic oc_t[3] = '{1'b1, 1'b0, 1'b1};
      logic af_t[3] = '{1'b0, 1'b1, 1'b0};
      logic [31:0] v;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wb_rd(OFF_PFS, PFS_RST);
      wb_rd(OFF_C0, C0_RST);
      wb_rd(OFF_C1, C1_RST);
      wb(1'b1, OFF_PFS, 8'hff);
      wb_rd(OFF_PFS, PFS_MASK);
      chk("pin_sel", 32'h1f, {27'h0, pfs_o});
      wb_rd(5'h1c, 8'h0);
      v = $random(seed);
      wb(1'b1, OFF_MA_LO, v[7:0]);
      wb_rd(OFF_MA_HI, 8'h0);
      wb_rd(OFF_MA_LO, 8'h0);
      wb(1'b1, OFF_MA_LO, v[7:0]);
      wb(1'b1, OFF_MA_HI, v[15:8]);
      wb_rd(OFF_MA_HI, {6'h0, v[9:8]});
      wb_rd(OFF_MA_LO, v[7:0]);
      wb(1'b1, OFF_CNT_HI, 8'h03);
      rdcnt(10'h0);
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, OFF_C0, {1'b0, ck_t[i], 1'b0, rp_t[i]});
         wb(1'b1, OFF_C0, {1'b0, ck_t[i], 1'b1, rp_t[i]});
         gap(gp_t[i]);
      end
      wb(1'b1, OFF_MA_LO, 8'h05);
      wb(1'b1, OFF_MA_HI, 8'h00);
      wb(1'b1, OFF_C1, 8'h01);
      for (int i = 6; i < 8; i++) begin
         wb(1'b1, OFF_C0, {1'b0, 3'(i), 1'b0, 3'h0});
         wb(1'b1, OFF_C0, {1'b0, 3'(i), 1'b1, 3'h0});
         n_ma = 0;
         n_pe = 0;
         pulse(8'd10);
         chk("match_events", 32'd2, 32'(n_ma));
         chk("period_events", 32'd0, 32'(n_pe));
      end
      wb(1'b1, OFF_C0, {1'b0, CK_EXT_RISE, 1'b0, 3'h0});
      wb(1'b1, OFF_C0, {1'b1, CK_EXT_RISE, 1'b1, 3'h0});
      pulse(8'd3);
      rdcnt(10'h0);
      wb(1'b1, OFF_C0, {1'b0, CK_EXT_RISE, 1'b1, 3'h0});
      pulse(8'd2);
      rdcnt(10'h2);
      wb(1'b1, OFF_C0, {1'b0, CK_EXT_RISE, 1'b0, 3'h0});
      pulse(8'd2);
      rdcnt(10'h2);
      wb(1'b1, OFF_C0, {1'b0, CK_EXT_RISE, 1'b1, 3'h0});
      rdcnt(10'h0);
      v = $random(seed);
      pinv <= v[1:0];
      wb(1'b1, OFF_PFS, 8'h03);
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, OFF_C0, {1'b0, CK_EXT_RISE, 1'b0, 3'h0});
         wb(1'b1, OFF_C1, {MD_CMP, act_t[i], oc_t[i], v[2], 2'h1});
         wb(1'b1, OFF_C0, {1'b0, CK_EXT_RISE, 1'b1, 3'h0});
         repeat (3) @(posedge clk);
         chk("first_init", {31'h0, oc_t[i] ^ v[2] ^ pinv[0]}, {31'h0, first_o});
         chk("second_init", {31'h0, oc_t[i] ^ v[2] ^ pinv[1]}, {31'h0, second_o});
         pulse(8'd5);
         chk("first_match", {31'h0, af_t[i] ^ v[2] ^ pinv[0]}, {31'h0, first_o});
         chk("second_match", {31'h0, af_t[i] ^ v[2] ^ pinv[1]}, {31'h0, second_o});
      end
      wb(1'b1, OFF_PFS, 8'h00);
      alt_a <= v[4];
      alt_b <= v[5];
      repeat (3) @(posedge clk);
      chk("pins_shared", {30'h0, v[5:4]}, {30'h0, second_o, first_o});
      final_report();
   end
endmodule // tb_ctm_timer
